// File: shared/bsc_pkg.sv
// Shared constants for the program-flow control block.
// Assumes a 16-bit word-addressed program counter and an 8-bit core.
package bsc_pkg;

	// ****************************************
	// Register map (byte addresses)
	// ****************************************
	localparam logic [3:0] ADDR_CTRL   = 4'h0; // Enable control
	localparam logic [3:0] ADDR_STATUS = 4'h4; // Last result, busy
	localparam logic [3:0] ADDR_PC     = 4'h8; // Program counter
	localparam logic [3:0] ADDR_FLAGS  = 4'hc; // Status flags register
	localparam logic [1:0] RESP_OKAY   = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	// ****************************************
	// Status flag positions and reset values
	// ****************************************
	localparam int FLAG_C = 0;
	localparam int FLAG_Z = 1;
	localparam int FLAG_N = 2;
	localparam int FLAG_V = 3;
	localparam int FLAG_S = 4;
	localparam int FLAG_H = 5;
	localparam int FLAG_I = 7;
	localparam logic [7:0]  FLAGS_RST = 8'h00;
	localparam logic [15:0] PC_RST    = 16'h0000;
	localparam int CTRL_EN_BIT   = 0;
	localparam logic CTRL_EN_RST = 1'b1;

	// ****************************************
	// Cycle counts per operation
	// ****************************************
	localparam logic [2:0] CYC_ONE   = 3'h1; // Compare, untaken test
	localparam logic [2:0] CYC_TWO   = 3'h2; // Taken branch, short skip
	localparam logic [2:0] CYC_THREE = 3'h3; // Long skip, pointer and relative calls
	localparam logic [2:0] CYC_FOUR  = 3'h4; // Direct call, returns

	// ****************************************
	// Program counter steps
	// ****************************************
	localparam logic [15:0] PC_STEP  = 16'h0001; // Next instruction
	localparam logic [15:0] SKIP_ONE = 16'h0002; // Skip one-word op
	localparam logic [15:0] SKIP_TWO = 16'h0003; // Skip two-word op

	// Operations decoded upstream
	typedef enum logic [4:0] {
		OP_NOP,
		OP_COMPARE,
		OP_COMPARE_WITH_BORROW,
		OP_COMPARE_IMMEDIATE,
		OP_EQUAL_COMPARE_SKIP,
		OP_REG_BIT_CLEAR_SKIP,
		OP_REG_BIT_SET_SKIP,
		OP_IO_BIT_CLEAR_SKIP,
		OP_IO_BIT_SET_SKIP,
		OP_FLAG_SET_BRANCH,
		OP_FLAG_CLEAR_BRANCH,
		OP_CARRY_CLEAR_BRANCH,
		OP_SAME_OR_HIGHER_BRANCH,
		OP_SIGNED_GE_BRANCH,
		OP_POINTER_CALL,
		OP_RELATIVE_CALL,
		OP_DIRECT_CALL,
		OP_SUB_RETURN,
		OP_INTERRUPT_RETURN
	} bsc_op_t;

	typedef enum logic [0:0] {
		ST_IDLE,
		ST_RUN
	} bsc_state_t;

endpackage

// File: sim/bsc_flow_ctrl_assertions.sv
// Concurrent checks on the program-flow control block.
// Assumes bsc_pkg is compiled first; sees only the top module ports.
module bsc_flow_ctrl_chk
	import bsc_pkg::*;
(
	input wire logic             aclk,
	input wire logic             aresetn,
	input wire logic             ce,
	input wire logic             op_valid,
	input wire bsc_pkg::bsc_op_t op_code,
	input wire logic [7:0]       op_rd_val,
	input wire logic [7:0]       op_rr_val,
	input wire logic [2:0]       op_bit_sel,
	input wire logic [11:0]      op_offset,
	input wire logic [15:0]      op_z_ptr,
	input wire logic [15:0]      op_stack_pc,
	input wire logic             op_next_two_word,
	input wire logic             op_ready,
	input wire logic             op_done,
	input wire logic [15:0]      pc_out,
	input wire logic [7:0]       flags_out,
	input wire logic             push_req,
	input wire logic [15:0]      push_addr,
	input wire logic             pop_req
);
	timeunit 1ns;
	timeprecision 1ps;
	// ****************************************
	// Helpers
	// ****************************************
	// Operation accepted at this edge
	wire logic        take = op_valid && op_ready && ce;
	// Short branch offset, sign extended
	wire logic [15:0] boff = {{9{op_offset[6]}}, op_offset[6:0]};
	// Bit under test in the register lane
	wire logic        rbit = op_rr_val[op_bit_sel];

	default clocking @(posedge aclk); endclocking
	default disable iff (!aresetn);

	// ****************************************
	// Properties
	// ****************************************
	chk_cmp_flags: assert property (
		take && op_code == OP_COMPARE |=> op_done &&
		flags_out[FLAG_Z] == ($past(op_rd_val) == $past(op_rr_val)))
		else $error("compare flag or timing wrong");
	chk_eq_skip: assert property (
		take && op_code == OP_EQUAL_COMPARE_SKIP && !op_next_two_word &&
		op_rd_val == op_rr_val |=> pc_out == $past(pc_out) + SKIP_ONE &&
		!op_done ##1 op_done)
		else $error("equal skip wrong");
	chk_long_skip: assert property (
		take && op_code == OP_REG_BIT_SET_SKIP && rbit && op_next_two_word
		|=> pc_out == $past(pc_out) + SKIP_TWO && !op_done ##1 !op_done
		##1 op_done)
		else $error("long skip wrong");
	chk_clr_fall: assert property (
		take && op_code == OP_REG_BIT_CLEAR_SKIP && rbit |=> op_done &&
		pc_out == $past(pc_out) + PC_STEP)
		else $error("bit clear skip fell wrong");
	chk_io_flags: assert property (
		take && op_code == OP_IO_BIT_SET_SKIP |=> $stable(flags_out))
		else $error("io skip touched flags");
	chk_br_taken: assert property (
		take && op_code == OP_FLAG_SET_BRANCH && flags_out[op_bit_sel] |=>
		pc_out == $past(pc_out) + $past(boff) + PC_STEP && !op_done
		##1 op_done)
		else $error("flag set branch wrong");
	chk_pcall: assert property (
		take && op_code == OP_POINTER_CALL |=> pc_out == $past(op_z_ptr) &&
		push_req && push_addr == $past(pc_out) + PC_STEP ##2 op_done)
		else $error("pointer call wrong");
	chk_interrupt_return: assert property (
		take && op_code == OP_INTERRUPT_RETURN |=> pop_req &&
		flags_out[FLAG_I] && pc_out == $past(op_stack_pc) ##3 op_done)
		else $error("interrupt return wrong");
	chk_dcall_len: assert property (
		take && op_code == OP_DIRECT_CALL |=> (!op_ready && !op_done)[*3]
		##1 op_done && op_ready)
		else $error("direct call length wrong");
endmodule

bind bsc_flow_ctrl bsc_flow_ctrl_chk bsc_flow_ctrl_chk_i (.aclk, .aresetn,
	.ce, .op_valid, .op_code, .op_rd_val, .op_rr_val, .op_bit_sel,
	.op_offset, .op_z_ptr, .op_stack_pc, .op_next_two_word, .op_ready,
	.op_done, .pc_out, .flags_out, .push_req, .push_addr, .pop_req);

// File: sim/bsc_flow_ctrl_test.sv
// Self-checking bench for the program-flow control block.
// Assumes bsc_pkg and the checker file are compiled before it.
module bsc_flow_ctrl_test import bsc_pkg::*;;
	timeunit 1ns;
	timeprecision 1ps;
	logic        aclk, aresetn, ce, op_valid, op_next_two_word;
	logic        s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_rready;
	logic        s_axi_arvalid, s_axi_awready, s_axi_wready, s_axi_bvalid;
	logic        s_axi_arready, s_axi_rvalid, op_ready, op_done;
	logic        push_req, pop_req;
	logic [3:0]  s_axi_awaddr, s_axi_wstrb, s_axi_araddr;
	logic [31:0] s_axi_wdata, s_axi_rdata, q;
	logic [1:0]  s_axi_bresp, s_axi_rresp, r;
	logic [7:0]  op_rd_val, op_rr_val, op_io_val, flags_out;
	logic [2:0]  op_bit_sel;
	logic [11:0] op_offset;
	logic [15:0] op_target, op_z_ptr, op_stack_pc, pc_out, push_addr;
	bsc_op_t     op_code;
	int          failures, cmp_count;
	logic [15:0] mp;	// Model program counter
	logic [7:0]  mf;	// Model flags

	bsc_flow_ctrl bsc_flow_ctrl_i (.aclk, .aresetn, .ce, .s_axi_awaddr,
		.s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
		.s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
		.s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
		.s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .op_valid,
		.op_code, .op_rd_val, .op_rr_val, .op_io_val, .op_bit_sel, .op_offset,
		.op_target, .op_z_ptr, .op_stack_pc, .op_next_two_word, .op_ready,
		.op_done, .pc_out, .flags_out, .push_req, .push_addr, .pop_req);

	// ****************************************
	// Clock, watchdog
	// ****************************************
	initial begin
		aclk = 1'b0;
		forever #2.5 aclk = ~aclk;
	end
	// Far beyond the roughly 2300 cycles the tests need
	initial begin
		#200000;
		failures++;
		results();
	end

	// ****************************************
	// Tasks
	// ****************************************
	task check(input logic [31:0] g, input logic [31:0] e);
		cmp_count++;
		if (g !== e) begin
			failures++;
			$display("[ERR] t=%0t got=%h exp=%h", $time, g, e);
		end
	endtask
	// One transfer; each channel held until its own ready
	task bus(input logic w, input logic [3:0] a, input logic [31:0] d);
		logic ah, wh, dn;
		int   n;
		@(posedge aclk);
		s_axi_awaddr <= a;
		s_axi_araddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= w;
		s_axi_wvalid <= w;
		s_axi_bready <= w;
		s_axi_arvalid <= !w;
		s_axi_rready <= !w;
		n = 0;
		dn = 1'b0;
		while (!dn && n < 100) begin
			#1;
			ah = w ? s_axi_awready : s_axi_arready;
			wh = s_axi_wready;
			dn = w ? s_axi_bvalid : s_axi_rvalid;
			r = w ? s_axi_bresp : s_axi_rresp;
			q = s_axi_rdata;
			@(posedge aclk);
			n++;
			// Release each channel at the edge that took it
			if (ah) begin
				s_axi_awvalid <= 1'b0;
				s_axi_arvalid <= 1'b0;
			end
			if (wh)
				s_axi_wvalid <= 1'b0;
			if (dn) begin
				s_axi_bready <= 1'b0;
				s_axi_rready <= 1'b0;
			end
		end
		if (!dn)
			failures++;
	endtask
	// Read one word and compare data and response
	task rchk(input logic [3:0] a, input logic [31:0] e, input logic [1:0] er);
		bus(1'b0, a, 32'h0);
		check(q, e);
		check({30'h0, r}, {30'h0, er});
	endtask
	// Preset pc and flags, run one operation, compare with the model
	task run_op(input bsc_op_t c, input logic [2:0] p);
		logic [31:0] d;
		logic [15:0] ep, ea;
		logic [7:0]  nf, mk;
		logic [2:0]  bs;
		logic        tk, ph, pp, sk, br;
		int          cy, ecy, df, rd, rr, cin;
		bs = 3'($urandom);
		d = $urandom;
		mp = d[15:0];
		bus(1'b1, ADDR_PC, d);
		d = $urandom;
		d[bs] = p[2];
		mf = d[7:0];
		bus(1'b1, ADDR_FLAGS, d);
		d = $urandom;
		// Tested bits follow the pass so each outcome is reached
		d[bs] = p[2];
		d[8 + bs] = p[2];
		d[16 + bs] = p[2];
		@(posedge aclk);
		op_code <= c;
		op_bit_sel <= bs;
		op_rd_val <= d[7:0];
		op_io_val <= d[15:8];
		op_rr_val <= p[1] ? d[7:0] : d[23:16];
		op_offset <= 12'($urandom);
		op_target <= 16'($urandom);
		op_z_ptr <= 16'($urandom);
		op_stack_pc <= 16'($urandom);
		op_next_two_word <= p[0];
		op_valid <= 1'b1;
		cy = 0;
		#1;
		while (!op_ready && cy < 50) begin
			@(posedge aclk);
			#1;
			cy++;
		end
		if (!op_ready)
			failures++;
		@(posedge aclk);
		op_valid <= 1'b0;
		#1;
		ph = push_req;
		pp = pop_req;
		ea = push_addr;
		cy = 1;
		while (!op_done && cy < 10) begin
			@(posedge aclk);
			#1;
			cy++;
		end
		// Reference model
		rd = op_rd_val;
		rr = op_rr_val;
		cin = (c == OP_COMPARE_WITH_BORROW) ? mf[FLAG_C] : 0;
		df = rd - rr - cin;
		nf = mf;
		mk = 8'hff;
		ep = mp + 16'h1;
		ecy = 1;
		sk = c inside {[OP_EQUAL_COMPARE_SKIP:OP_IO_BIT_SET_SKIP]};
		br = c inside {[OP_FLAG_SET_BRANCH:OP_SIGNED_GE_BRANCH]};
		case (c)
			OP_EQUAL_COMPARE_SKIP: tk = rd == rr;
			OP_REG_BIT_CLEAR_SKIP: tk = !op_rr_val[bs];
			OP_REG_BIT_SET_SKIP:   tk = op_rr_val[bs];
			OP_IO_BIT_CLEAR_SKIP:  tk = !op_io_val[bs];
			OP_IO_BIT_SET_SKIP:    tk = op_io_val[bs];
			OP_FLAG_SET_BRANCH:    tk = mf[bs];
			OP_FLAG_CLEAR_BRANCH:  tk = !mf[bs];
			OP_SIGNED_GE_BRANCH:   tk = !(mf[FLAG_N] ^ mf[FLAG_V]);
			default:               tk = !mf[FLAG_C];
		endcase
		if (sk && tk) begin
			ep = mp + 16'h2 + 16'(op_next_two_word);
			ecy = 2 + op_next_two_word;
		end
		if (br && tk) begin
			ep = mp + {{9{op_offset[6]}}, op_offset[6:0]} + 16'h1;
			ecy = 2;
		end
		if (c < OP_EQUAL_COMPARE_SKIP) begin
			// Compares; the sign flag is left out of the comparison
			mk = 8'hef;
			nf[FLAG_C] = df < 0;
			nf[FLAG_Z] = df[7:0] == 0 && (c != OP_COMPARE_WITH_BORROW || mf[1]);
			nf[FLAG_N] = df[7];
			nf[FLAG_V] = ((rd ^ rr) & (rd ^ df) & 128) != 0;
			nf[FLAG_H] = (rd % 16 - rr % 16 - cin) < 0;
		end
		if (c == OP_POINTER_CALL)
			ep = op_z_ptr;
		if (c == OP_RELATIVE_CALL)
			ep = mp + {{4{op_offset[11]}}, op_offset} + 16'h1;
		if (c == OP_DIRECT_CALL)
			ep = op_target;
		if (c >= OP_SUB_RETURN)
			ep = op_stack_pc;
		if (c == OP_INTERRUPT_RETURN)
			nf[FLAG_I] = 1'b1;
		if (c >= OP_POINTER_CALL)
			ecy = (c == OP_DIRECT_CALL || c >= OP_SUB_RETURN) ? 4 : 3;
		check(cy, ecy);
		check({16'h0, pc_out}, {16'h0, ep});
		check({24'h0, flags_out & mk}, {24'h0, nf & mk});
		check({31'h0, ph}, {31'h0, c inside {[OP_POINTER_CALL:OP_DIRECT_CALL]}});
		if (ph)
			check({16'h0, ea}, {16'h0, mp + (c == OP_DIRECT_CALL ? 16'h2 : 16'h1)});
		check({31'h0, pp}, {31'h0, c >= OP_SUB_RETURN});
		bus(1'b0, ADDR_STATUS, 32'h0);
		tk = tk && (sk || br);
		check({27'h0, q[4:0]}, {27'h0, tk, 3'(ecy), 1'b0});
	endtask
	// Count line, verdict, end of run
	task results;
		$display("compares %0d mismatches %0d", cmp_count, failures);
		if (failures == 0 && cmp_count > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask

	// ****************************************
	// Main sequence
	// ****************************************
	initial begin
		{aresetn, op_valid, op_next_two_word, s_axi_awvalid} = '0;
		{s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
		{s_axi_awaddr, s_axi_araddr, s_axi_wdata, op_rd_val} = '0;
		{op_rr_val, op_io_val, op_bit_sel, op_offset, op_target} = '0;
		{op_z_ptr, op_stack_pc} = '0;
		op_code = OP_NOP;
		ce = 1'b1;
		s_axi_wstrb = 4'hf;
		void'($urandom(8700));
		repeat (12) @(posedge aclk);
		aresetn <= 1'b1;
		// Reset values, then a word outside the map
		rchk(ADDR_CTRL, 32'h1, RESP_OKAY);
		rchk(ADDR_PC, 32'h0, RESP_OKAY);
		rchk(ADDR_FLAGS, 32'h0, RESP_OKAY);
		rchk(4'h2, 32'h0, RESP_SLVERR);
		$display("test reset done");
		// Disabled block refuses operations
		bus(1'b1, ADDR_CTRL, 32'h0);
		#1;
		check({31'h0, op_ready}, 32'h0);
		bus(1'b1, ADDR_CTRL, 32'h1);
		// Clock enable low freezes an offered call
		@(posedge aclk);
		ce <= 1'b0;
		op_code <= OP_DIRECT_CALL;
		op_target <= 16'h1234;
		op_valid <= 1'b1;
		repeat (4) @(posedge aclk);
		#1;
		check({15'h0, op_done, pc_out}, 32'h0);
		@(posedge aclk);
		ce <= 1'b1;
		op_valid <= 1'b0;
		$display("test refuse done");
		// Unmapped write answers an error, byte strobes honoured
		bus(1'b1, 4'h2, 32'h0);
		check({30'h0, r}, {30'h0, RESP_SLVERR});
		s_axi_wstrb <= 4'h1;
		bus(1'b1, ADDR_PC, 32'hffff);
		check({30'h0, r}, {30'h0, RESP_OKAY});
		s_axi_wstrb <= 4'hf;
		rchk(ADDR_PC, 32'h00ff, RESP_OKAY);
		$display("test bus done");
		// Every operation except OP_NOP under every corner combination
		for (int i = 0; i < 144; i++)
			run_op(bsc_op_t'(1 + i % 18), 3'(i / 18));
		$display("test operations done");
		results();
	end
endmodule

// File: src/bsc_flow_ctrl.sv
// Program-flow control: compares, skips, branches, calls and returns.
// Assumes an upstream decoder that presents one operation with operands,
// and a stack unit that pushes/pops return addresses on request.
module bsc_flow_ctrl (
	input  wire logic              aclk,
	input  wire logic              aresetn,
	input  wire logic              ce,
	// AXI4-Lite slave
	input  wire logic [3:0]        s_axi_awaddr,
	input  wire logic              s_axi_awvalid,
	output logic                   s_axi_awready,
	input  wire logic [31:0]       s_axi_wdata,
	input  wire logic [3:0]        s_axi_wstrb,
	input  wire logic              s_axi_wvalid,
	output logic                   s_axi_wready,
	output logic [1:0]             s_axi_bresp,
	output logic                   s_axi_bvalid,
	input  wire logic              s_axi_bready,
	input  wire logic [3:0]        s_axi_araddr,
	input  wire logic              s_axi_arvalid,
	output logic                   s_axi_arready,
	output logic [31:0]            s_axi_rdata,
	output logic [1:0]             s_axi_rresp,
	output logic                   s_axi_rvalid,
	input  wire logic              s_axi_rready,
	// Operation port
	input  wire logic              op_valid,
	input  wire bsc_pkg::bsc_op_t  op_code,
	input  wire logic [7:0]        op_rd_val,
	input  wire logic [7:0]        op_rr_val,
	input  wire logic [7:0]        op_io_val,
	input  wire logic [2:0]        op_bit_sel,
	input  wire logic [11:0]       op_offset,
	input  wire logic [15:0]       op_target,
	input  wire logic [15:0]       op_z_ptr,
	input  wire logic [15:0]       op_stack_pc,
	input  wire logic              op_next_two_word,
	// Results
	output logic                   op_ready,
	output logic                   op_done,
	output logic [15:0]            pc_out,
	output logic [7:0]             flags_out,
	output logic                   push_req,
	output logic [15:0]            push_addr,
	output logic                   pop_req
);
	import bsc_pkg::*;

	// ****************************************
	// State
	// ****************************************
	bsc_state_t  state_reg;        // Idle or counting cycles
	logic [2:0]  cnt_reg;          // Cycles still to spend
	logic [2:0]  last_cyc_reg;     // Cycle count of last op
	logic        last_taken_reg;   // Last op skipped or branched
	logic        en_reg;           // Software enable
	logic [15:0] pc_reg;           // Program counter
	logic [7:0]  flags_reg;        // Status flags register
	logic        done_reg;         // Completion pulse
	logic        push_reg;         // Push request pulse
	logic [15:0] push_addr_reg;    // Return address to push
	logic        pop_reg;          // Pop request pulse
	logic        ready_reg;        // Idle and enabled, registered
	logic        awready_reg;
	logic        wready_reg;
	logic        bvalid_reg;
	logic [1:0]  bresp_reg;
	logic        arready_reg;
	logic        rvalid_reg;
	logic [1:0]  rresp_reg;
	logic [31:0] rdata_reg;

	// ****************************************
	// Compare datapath
	// ****************************************
	wire        is_cpc   = (op_code == OP_COMPARE_WITH_BORROW);
	wire        is_cpi   = (op_code == OP_COMPARE_IMMEDIATE);
	// Immediate arrives on the rr operand lane
	wire [7:0]  cmp_b    = op_rr_val;
	wire        cmp_cin  = is_cpc & flags_reg[FLAG_C];
	wire [7:0]  cmp_res  = op_rd_val - cmp_b - {7'h00, cmp_cin};
	wire        h_flag   = (~op_rd_val[3] & cmp_b[3]) |
	                       (cmp_b[3] & cmp_res[3]) |
	                       (cmp_res[3] & ~op_rd_val[3]);
	wire        c_flag   = (~op_rd_val[7] & cmp_b[7]) |
	                       (cmp_b[7] & cmp_res[7]) |
	                       (cmp_res[7] & ~op_rd_val[7]);
	wire        v_flag   = (op_rd_val[7] & ~cmp_b[7] & ~cmp_res[7]) |
	                       (~op_rd_val[7] & cmp_b[7] & cmp_res[7]);
	wire        n_flag   = cmp_res[7];
	// With borrow, zero is only kept, never set, for chained compares
	wire        z_flag   = (cmp_res == 8'h00) &
	                       (~is_cpc | flags_reg[FLAG_Z]);
	wire [7:0]  cmp_flags = {flags_reg[7:6], h_flag, n_flag ^ v_flag,
	                         v_flag, n_flag, z_flag, c_flag};
	wire        is_cmp   = (op_code == OP_COMPARE) | is_cpc | is_cpi;

	// ****************************************
	// Condition decode
	// ****************************************
	wire reg_bit  = op_rr_val[op_bit_sel];
	wire io_bit   = op_io_val[op_bit_sel];
	wire sel_flag = flags_reg[op_bit_sel];
	logic skip_cond;    // Next instruction is skipped
	logic br_cond;      // Relative branch taken
	logic is_skip;
	logic is_branch;
	always_comb begin
		skip_cond = 1'b0;
		br_cond   = 1'b0;
		is_skip   = 1'b0;
		is_branch = 1'b0;
		case (op_code)
			OP_EQUAL_COMPARE_SKIP: begin
				is_skip   = 1'b1;
				skip_cond = (op_rd_val == op_rr_val);
			end
			OP_REG_BIT_CLEAR_SKIP: begin
				is_skip   = 1'b1;
				skip_cond = ~reg_bit;
			end
			OP_REG_BIT_SET_SKIP: begin
				is_skip   = 1'b1;
				skip_cond = reg_bit;
			end
			OP_IO_BIT_CLEAR_SKIP: begin
				is_skip   = 1'b1;
				skip_cond = ~io_bit;
			end
			OP_IO_BIT_SET_SKIP: begin
				is_skip   = 1'b1;
				skip_cond = io_bit;
			end
			OP_FLAG_SET_BRANCH: begin
				is_branch = 1'b1;
				br_cond   = sel_flag;
			end
			OP_FLAG_CLEAR_BRANCH: begin
				is_branch = 1'b1;
				br_cond   = ~sel_flag;
			end
			OP_CARRY_CLEAR_BRANCH, OP_SAME_OR_HIGHER_BRANCH: begin
				is_branch = 1'b1;
				br_cond   = ~flags_reg[FLAG_C];
			end
			OP_SIGNED_GE_BRANCH: begin
				is_branch = 1'b1;
				br_cond   = ~(flags_reg[FLAG_N] ^ flags_reg[FLAG_V]);
			end
			default: begin
				skip_cond = 1'b0;
			end
		endcase
	end

	// ****************************************
	// Next program counter and cycle count
	// ****************************************
	wire [15:0] br_off  = {{9{op_offset[6]}}, op_offset[6:0]};
	wire [15:0] rc_off  = {{4{op_offset[11]}}, op_offset};
	wire [15:0] skip_by = op_next_two_word ? SKIP_TWO : SKIP_ONE;
	wire [2:0]  skip_cy = op_next_two_word ? CYC_THREE : CYC_TWO;
	logic [15:0] pc_next;
	logic [2:0]  cyc_next;
	logic        push_next;
	logic        pop_next;
	logic [15:0] ret_next;
	always_comb begin
		pc_next   = pc_reg + PC_STEP;
		cyc_next  = CYC_ONE;
		push_next = 1'b0;
		pop_next  = 1'b0;
		ret_next  = pc_reg + PC_STEP;
		if (is_skip && skip_cond) begin
			pc_next  = pc_reg + skip_by;
			cyc_next = skip_cy;
		end else if (is_branch && br_cond) begin
			pc_next  = pc_reg + br_off + PC_STEP;
			cyc_next = CYC_TWO;
		end else begin
			case (op_code)
				OP_POINTER_CALL: begin
					pc_next   = op_z_ptr;
					cyc_next  = CYC_THREE;
					push_next = 1'b1;
				end
				OP_RELATIVE_CALL: begin
					pc_next   = pc_reg + rc_off + PC_STEP;
					cyc_next  = CYC_THREE;
					push_next = 1'b1;
				end
				OP_DIRECT_CALL: begin
					pc_next   = op_target;
					cyc_next  = CYC_FOUR;
					push_next = 1'b1;
					ret_next  = pc_reg + SKIP_ONE; // Two-word opcode
				end
				OP_SUB_RETURN, OP_INTERRUPT_RETURN: begin
					pc_next  = op_stack_pc;
					cyc_next = CYC_FOUR;
					pop_next = 1'b1;
				end
				default: begin
					cyc_next = CYC_ONE;
				end
			endcase
		end
	end

	// ****************************************
	// Register bus decode
	// ****************************************
	wire op_go    = ce & op_valid & en_reg & (state_reg == ST_IDLE);
	wire wr_go    = awready_reg & s_axi_awvalid & wready_reg & s_axi_wvalid;
	wire wr_start = s_axi_awvalid & s_axi_wvalid & ~awready_reg &
	                ~bvalid_reg;
	wire rd_start = s_axi_arvalid & ~arready_reg & ~rvalid_reg;
	wire rd_go    = arready_reg & s_axi_arvalid;
	wire [31:0] wmask = {{8{s_axi_wstrb[3]}}, {8{s_axi_wstrb[2]}},
	                     {8{s_axi_wstrb[1]}}, {8{s_axi_wstrb[0]}}};
	wire [31:0] ctrl_rd   = {31'h0, en_reg};
	wire [31:0] status_rd = {27'h0, last_taken_reg, last_cyc_reg,
	                         state_reg == ST_RUN};
	wire [31:0] pc_rd     = {16'h0, pc_reg};
	wire [31:0] flags_rd  = {24'h0, flags_reg};
	wire [31:0] pc_wr     = (pc_rd & ~wmask) | (s_axi_wdata & wmask);
	wire [31:0] fl_wr     = (flags_rd & ~wmask) | (s_axi_wdata & wmask);
	wire [31:0] ct_wr     = (ctrl_rd & ~wmask) | (s_axi_wdata & wmask);
	wire wr_ctrl  = wr_go & (s_axi_awaddr == ADDR_CTRL);
	wire wr_pc    = wr_go & (s_axi_awaddr == ADDR_PC);
	wire wr_flags = wr_go & (s_axi_awaddr == ADDR_FLAGS);
	wire wr_hit   = wr_ctrl | wr_pc | wr_flags |
	                (s_axi_awaddr == ADDR_STATUS);
	logic [31:0] rd_data;
	logic        rd_hit;
	always_comb begin
		rd_hit = 1'b1;
		case (s_axi_araddr)
			ADDR_CTRL:   rd_data = ctrl_rd;
			ADDR_STATUS: rd_data = status_rd;
			ADDR_PC:     rd_data = pc_rd;
			ADDR_FLAGS:  rd_data = flags_rd;
			default: begin
				rd_data = 32'h0;
				rd_hit  = 1'b0;
			end
		endcase
	end

	// ****************************************
	// Sequencer: accept op, spend its cycles
	// ****************************************
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			state_reg      <= ST_IDLE;
			cnt_reg        <= CYC_ONE;
			last_cyc_reg   <= CYC_ONE;
			last_taken_reg <= 1'b0;
			done_reg       <= 1'b0;
			push_reg       <= 1'b0;
			pop_reg        <= 1'b0;
			push_addr_reg  <= PC_RST;
		end else if (ce) begin
			done_reg <= 1'b0;
			push_reg <= 1'b0;
			pop_reg  <= 1'b0;
			if (op_go) begin
				push_reg       <= push_next;
				pop_reg        <= pop_next;
				push_addr_reg  <= ret_next;
				last_cyc_reg   <= cyc_next;
				last_taken_reg <= (is_skip & skip_cond) |
				                  (is_branch & br_cond);
				cnt_reg        <= cyc_next;
				// One-cycle ops finish at once
				state_reg      <= (cyc_next == CYC_ONE) ? ST_IDLE : ST_RUN;
				done_reg       <= (cyc_next == CYC_ONE);
			end else if (state_reg == ST_RUN) begin
				cnt_reg <= cnt_reg - CYC_ONE;
				if (cnt_reg == CYC_TWO) begin
					state_reg <= ST_IDLE;
					done_reg  <= 1'b1;
				end
			end
		end
	end

	// Program counter; an op outranks a bus write in the same cycle
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			pc_reg <= PC_RST;
		end else if (ce) begin
			if (op_go) begin
				pc_reg <= pc_next;
			end else if (wr_pc) begin
				pc_reg <= pc_wr[15:0];
			end
		end
	end

	// Flags: compares and bus writes change them, interrupt return sets I
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			flags_reg <= FLAGS_RST;
		end else if (ce) begin
			if (op_go && is_cmp) begin
				flags_reg <= cmp_flags;
			end else if (op_go && op_code == OP_INTERRUPT_RETURN) begin
				flags_reg[FLAG_I] <= 1'b1;
			end else if (wr_flags) begin
				flags_reg <= fl_wr[7:0];
			end
		end
	end

	// Ready kept in a flop so the port has no logic behind it
	wire en_next   = wr_ctrl ? ct_wr[CTRL_EN_BIT] : en_reg;
	wire idle_next = op_go ? (cyc_next == CYC_ONE) :
	                 (state_reg == ST_IDLE) | (cnt_reg == CYC_TWO);
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			ready_reg <= CTRL_EN_RST;
		end else if (ce) begin
			ready_reg <= idle_next & en_next;
		end
	end

	// ****************************************
	// AXI4-Lite slave handshakes
	// ****************************************
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			en_reg      <= CTRL_EN_RST;
			awready_reg <= 1'b0;
			wready_reg  <= 1'b0;
			bvalid_reg  <= 1'b0;
			bresp_reg   <= RESP_OKAY;
			arready_reg <= 1'b0;
			rvalid_reg  <= 1'b0;
			rresp_reg   <= RESP_OKAY;
			rdata_reg   <= 32'h0;
		end else if (ce) begin
			// Both channels taken together, one cycle after both valid
			awready_reg <= wr_start;
			wready_reg  <= wr_start;
			if (wr_ctrl) begin
				en_reg <= ct_wr[CTRL_EN_BIT];
			end
			if (wr_go) begin
				bvalid_reg <= 1'b1;
				bresp_reg  <= wr_hit ? RESP_OKAY : RESP_SLVERR;
			end else if (s_axi_bready) begin
				bvalid_reg <= 1'b0;
			end
			arready_reg <= rd_start;
			if (rd_go) begin
				rvalid_reg <= 1'b1;
				rdata_reg  <= rd_data;
				rresp_reg  <= rd_hit ? RESP_OKAY : RESP_SLVERR;
			end else if (s_axi_rready) begin
				rvalid_reg <= 1'b0;
			end
		end
	end

	// ****************************************
	// Outputs, all from flip-flops
	// ****************************************
	assign s_axi_awready = awready_reg;
	assign s_axi_wready  = wready_reg;
	assign s_axi_bvalid  = bvalid_reg;
	assign s_axi_bresp   = bresp_reg;
	assign s_axi_arready = arready_reg;
	assign s_axi_rvalid  = rvalid_reg;
	assign s_axi_rdata   = rdata_reg;
	assign s_axi_rresp   = rresp_reg;
	assign op_ready      = ready_reg;
	assign op_done       = done_reg;
	assign pc_out        = pc_reg;
	assign flags_out     = flags_reg;
	assign push_req      = push_reg;
	assign push_addr     = push_addr_reg;
	assign pop_req       = pop_reg;

endmodule
